// ===== src_board_model.sv
// board straps and reset source facing the strap and reset block
`timescale 1ns/100ps

module src_board_model
  import src_pkg::*;
(
  // clock
  input  wire logic   hclk,
  // board side
  output logic        hresetn,
  output src_straps_t straps
);
  initial begin
    hresetn = 1'b0;
    straps  = '0;
  end

  task automatic set_pins(input logic fsel, input logic role, input logic rate);
    @(posedge hclk);
    straps <= '{fast_select_pin: fsel, role_pin: role, rate_family_pin: rate};
  endtask

  // low pulse, 500 cycles meets the minimum
  task automatic pulse_reset(input int cycles);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (cycles) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
endmodule

// ===== src_cfg.svh
// constants for the strap and reset control block
`ifndef SRC_CFG_SVH
`define SRC_CFG_SVH

// master clock period in ns
`define SRC_CLK_PERIOD_NS 100

// shortest reset pulse the board must give, and its cycles
`define SRC_MIN_RST_US 50
`define SRC_MIN_RST_CYC ((`SRC_MIN_RST_US * 1000 + `SRC_CLK_PERIOD_NS - 1) / `SRC_CLK_PERIOD_NS)

// internal reset stretch after release, and its cycles
`define SRC_STRETCH_MS 500
`define SRC_STRETCH_CYC ((`SRC_STRETCH_MS * 1000000) / `SRC_CLK_PERIOD_NS)
`define SRC_CNT_W 23

// register indices, byte address is four times the index
`define SRC_IDX_STATUS 6'h09
`define SRC_IDX_INCFG 6'h0B
`define SRC_IDX_ROLE 6'h13
`define SRC_IDX_SEQ 6'h14

// field positions
`define SRC_BIT_ROLE_STS 1
`define SRC_BIT_RATE 2
`define SRC_BIT_FSE 4
`define SRC_BIT_ROLE_CTRL 0
`define SRC_BIT_SEQ_RUN 0
`define SRC_BIT_SEQ_PAIR 1
`define SRC_BIT_SEQ_MASTER 2
`define SRC_BIT_SEQ_PVALID 3

// reset values before strap capture
`define SRC_RST_FSE 1'h0
`define SRC_RST_RATE 1'h0
`define SRC_RST_ROLE_CTRL 1'h0
`define SRC_RST_PAIR 1'h0

`endif

// ===== src_pkg.sv
// types shared by the strap and reset control block
package src_pkg;

  typedef enum logic {
    SRC_HOLD = 1'b0,
    SRC_RUN  = 1'b1
  } src_state_t;

  typedef struct packed {
    logic fast_select_pin;
    logic role_pin;
    logic rate_family_pin;
  } src_straps_t;

  typedef struct packed {
    logic run;
    logic pair_valid;
    logic pair_one_three;
    logic role_master;
    logic rate_sonet;
  } src_ctrl_t;

endpackage

// ===== src_strap_reset.sv
// strap capture, reset stretch, fast select and role logic
// Functional notes
// RULE1: reset input held low at least 50 us fully resets the device.
// RULE2: after reset release, internal logic stays in reset a further 500 ms.
// RULE3: during reset, fast select enable bit loads from the fast select pin.
// RULE4: after reset with fast select enabled, pin picks pair one/three or two/four.
// RULE5: after reset with fast select disabled, the fast select pin is ignored.
// RULE6: master or slave role comes from role pin combined with role control bit.
// RULE7: role pin level is reported continuously in a read-only status bit.
// RULE8: during reset, rate family bit loads from the rate family pin.
// RULE9: after reset the rate family pin is ignored; only the bit governs.
// RULE10: all logic runs from the single master clock.
// RULE11: strap and role pins pass a two-flop synchroniser before use.
// RULE12: strap defaults are latched on the last cycle of the reset stretch.
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "src_cfg.svh"

module src_strap_reset
  import src_pkg::*;
#(
  parameter int unsigned STRETCH_CYCLES = `SRC_STRETCH_CYC
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // board straps
  input  wire src_straps_t straps,
  // control to the timing paths
  output src_ctrl_t        ctrl
);

  localparam logic [`SRC_CNT_W-1:0] LAST_CNT = `SRC_CNT_W'(STRETCH_CYCLES - 1);

  // register index of a byte address
  function automatic logic [5:0] reg_idx(input logic [31:0] a);
    reg_idx = a[7:2];
  endfunction

  // synchroniser
  src_straps_t sync1_r;
  src_straps_t sync2_r;
  src_straps_t sync1_nxt;
  src_straps_t sync2_nxt;

  // sequencer
  src_state_t             st_r;
  src_state_t             st_nxt;
  logic [`SRC_CNT_W-1:0]  cnt_r;
  logic [`SRC_CNT_W-1:0]  cnt_nxt;

  // configuration state
  logic fse_r;
  logic fse_nxt;
  logic rate_r;
  logic rate_nxt;
  logic role_ctrl_r;
  logic role_ctrl_nxt;
  logic pair_r;
  logic pair_nxt;
  logic master_r;
  logic master_nxt;

  // bus state
  logic        wr_pend_r;
  logic        wr_pend_nxt;
  logic [5:0]  idx_r;
  logic [5:0]  idx_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        accept;
  logic        running;

  // read mux
  function automatic logic [31:0] rd_word(input logic [5:0] i);
    rd_word = 32'h0;
    unique case (i)
      `SRC_IDX_STATUS: begin
        // RULE7 live role level
        rd_word[`SRC_BIT_ROLE_STS] = sync2_r.role_pin;
        rd_word[`SRC_BIT_RATE]     = rate_r;
      end
      `SRC_IDX_INCFG: begin
        rd_word[`SRC_BIT_FSE] = fse_r;
      end
      `SRC_IDX_ROLE: begin
        rd_word[`SRC_BIT_ROLE_CTRL] = role_ctrl_r;
      end
      `SRC_IDX_SEQ: begin
        rd_word[`SRC_BIT_SEQ_RUN]    = running;
        rd_word[`SRC_BIT_SEQ_PAIR]   = pair_r;
        rd_word[`SRC_BIT_SEQ_MASTER] = master_r;
        rd_word[`SRC_BIT_SEQ_PVALID] = running & fse_r;
      end
      default: rd_word = 32'h0;
    endcase
  endfunction

  assign running = (st_r == SRC_RUN);

  // RULE11 two-flop pin synchroniser
  always_comb begin
    sync1_nxt = straps;
    sync2_nxt = sync1_r;
  end

  // RULE10 single master clock domain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // straps are only sampled once the pin reset lifts; the stretch covers it
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // RULE2 stretch counter holds logic in reset
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      SRC_HOLD: begin
        if (cnt_r == LAST_CNT) begin
          st_nxt = SRC_RUN;
        end else begin
          cnt_nxt = cnt_r + `SRC_CNT_W'(1);
        end
      end
      SRC_RUN: begin
        st_nxt = SRC_RUN;
      end
    endcase
  end

  // RULE1 any low on the reset pin restarts everything
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r  <= SRC_HOLD;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // configuration bits
  always_comb begin
    fse_nxt       = fse_r;
    rate_nxt      = rate_r;
    role_ctrl_nxt = role_ctrl_r;
    pair_nxt      = pair_r;
    if (!running) begin
      // RULE3 RULE8 RULE12 load straps every hold cycle, last one sticks
      fse_nxt  = sync2_r.fast_select_pin;
      rate_nxt = sync2_r.rate_family_pin;
    end else if (wr_pend_r) begin
      unique case (idx_r)
        `SRC_IDX_INCFG:  fse_nxt       = hwdata[`SRC_BIT_FSE];
        // RULE9 only software moves the rate bit now
        `SRC_IDX_STATUS: rate_nxt      = hwdata[`SRC_BIT_RATE];
        `SRC_IDX_ROLE:   role_ctrl_nxt = hwdata[`SRC_BIT_ROLE_CTRL];
        default:         fse_nxt       = fse_r;
      endcase
    end
    // a disabled pair keeps its last choice so the path does not hop
    // RULE4 RULE5 pin steers the pair only when enabled
    if (running && fse_r) begin
      pair_nxt = sync2_r.fast_select_pin;
    end
    // RULE6 control bit inverts the pin sense
    master_nxt = sync2_r.role_pin ^ role_ctrl_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fse_r       <= `SRC_RST_FSE;
      rate_r      <= `SRC_RST_RATE;
      role_ctrl_r <= `SRC_RST_ROLE_CTRL;
      pair_r      <= `SRC_RST_PAIR;
      master_r    <= 1'b0;
    end else begin
      fse_r       <= fse_nxt;
      rate_r      <= rate_nxt;
      role_ctrl_r <= role_ctrl_nxt;
      pair_r      <= pair_nxt;
      master_r    <= master_nxt;
    end
  end

  // bus slave, zero wait states; writes during the stretch are dropped
  assign accept = hsel & hready & htrans[1];

  always_comb begin
    wr_pend_nxt = accept & hwrite;
    idx_nxt     = accept ? reg_idx(haddr) : idx_r;
    rdata_nxt   = (accept && !hwrite) ? rd_word(reg_idx(haddr)) : 32'h0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      idx_r     <= 6'h00;
      rdata_r   <= 32'h0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      idx_r     <= idx_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  // one driver for the whole bundle
  assign ctrl = '{
    run:            running,
    pair_valid:     running & fse_r,
    pair_one_three: pair_r,
    role_master:    master_r,
    rate_sonet:     rate_r
  };

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_stretch_length: assert property ( // RULE2
    $rose(running) |-> $past(cnt_r) == LAST_CNT)
    else $error("run began before the stretch ended");

  a_reset_holds: assert property ( // RULE1
    $rose(hresetn) |-> !running)
    else $error("logic left reset with the pin");

  a_fse_capture: assert property ( // RULE3
    !running |=> fse_r == $past(sync2_r.fast_select_pin))
    else $error("enable bit not loaded from pin");

  a_pair_follow: assert property ( // RULE4
    running && fse_r |=> pair_r == $past(sync2_r.fast_select_pin))
    else $error("pair does not follow pin");

  a_pair_ignore: assert property ( // RULE5
    running && !fse_r |=> $stable(pair_r))
    else $error("pair moved while disabled");

  a_role_combine: assert property ( // RULE6
    ##1 master_r == $past(sync2_r.role_pin ^ role_ctrl_r))
    else $error("role does not match pin and bit");

  a_role_status: assert property ( // RULE7
    accept && !hwrite && reg_idx(haddr) == `SRC_IDX_STATUS
    |=> hrdata[`SRC_BIT_ROLE_STS] == $past(sync2_r.role_pin))
    else $error("role status bit wrong");

  a_rate_capture: assert property ( // RULE8
    !running |=> rate_r == $past(sync2_r.rate_family_pin))
    else $error("rate bit not loaded from pin");

  a_rate_frozen: assert property ( // RULE9
    running && !(wr_pend_r && idx_r == `SRC_IDX_STATUS) |=> $stable(rate_r))
    else $error("rate bit moved without a write");

  a_sync_delay: assert property ( // RULE11
    $past(hresetn, 2) |-> sync2_r == $past(straps, 2))
    else $error("synchroniser delay is not two");

  a_last_latch: assert property ( // RULE12
    $rose(running) |-> fse_r == $past(sync2_r.fast_select_pin)
    && rate_r == $past(sync2_r.rate_family_pin))
    else $error("defaults not from last hold cycle");

  a_run_sticky: assert property ( // RULE2
    running |=> running)
    else $error("run dropped without a pin reset");

  // the release edge itself still sees the flops in reset
  a_stretch_count: assert property ( // RULE2
    hresetn && !running && cnt_r != LAST_CNT |=> cnt_r == $past(cnt_r) + `SRC_CNT_W'(1))
    else $error("stretch counter skipped a step");

  a_fse_write: assert property ( // RULE4
    running && wr_pend_r && idx_r == `SRC_IDX_INCFG
    |=> fse_r == $past(hwdata[`SRC_BIT_FSE]))
    else $error("enable bit missed a write");

  a_role_write: assert property ( // RULE6
    running && wr_pend_r && idx_r == `SRC_IDX_ROLE
    |=> role_ctrl_r == $past(hwdata[`SRC_BIT_ROLE_CTRL]))
    else $error("role control bit missed a write");

  a_rate_write: assert property ( // RULE9
    running && wr_pend_r && idx_r == `SRC_IDX_STATUS
    |=> rate_r == $past(hwdata[`SRC_BIT_RATE]))
    else $error("rate bit missed a write");

  a_read_idle: assert property (
    !(accept && !hwrite) |=> hrdata == 32'h0)
    else $error("read data outside its data phase");

endmodule

// ===== test_strap_reset_control.sv
// self-checking bench for the strap and reset control block
`timescale 1ns/100ps

module test_strap_reset_control
  import src_pkg::*;
;
  // short stretch keeps the run brief
  localparam int S = 20;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] d;
  src_straps_t straps;
  src_ctrl_t   ctrl;
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;

  src_board_model src_board_model_inst (.hclk(hclk), .hresetn(hresetn), .straps(straps));

  src_strap_reset #(.STRETCH_CYCLES(S)) src_strap_reset_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .straps(straps), .ctrl(ctrl));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic run_wait;
    int n;
    n = 0;
    while (ctrl.run !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    check(32'(n >= S && n <= S + 2), 32'h1);
  endtask

  // hang guard, the sequence needs well under a thousand cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} <= '0;
    hsize <= 3'h2;
    src_board_model_inst.set_pins(1'b1, 1'b1, 1'b1);
    src_board_model_inst.pulse_reset(16);
    run_wait();
    xfer(1'b0, 32'h2C, 32'h0);
    check(d & 32'h10, 32'h10);
    xfer(1'b0, 32'h24, 32'h0);
    check(d & 32'h6, 32'h6);
    check(32'({ctrl.pair_valid, ctrl.pair_one_three}), 32'h3);
    xfer(1'b0, 32'h50, 32'h0);
    check(d & 32'hF, 32'hF);
    check(32'(hresp), 32'h0);
    src_board_model_inst.set_pins(1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge hclk);
    check(32'(ctrl.pair_one_three), 32'h0);
    check(32'(ctrl.rate_sonet), 32'h1);
    xfer(1'b1, 32'h24, 32'h0);
    xfer(1'b0, 32'h24, 32'h0);
    check(d & 32'h4, 32'h0);
    xfer(1'b1, 32'h2C, 32'h0);
    src_board_model_inst.set_pins(1'b1, 1'b1, 1'b1);
    repeat (4) @(posedge hclk);
    check(32'({ctrl.pair_valid, ctrl.pair_one_three, ctrl.rate_sonet}), 32'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 32'h4C, 32'(i[0]));
      src_board_model_inst.set_pins(1'b1, i[1], 1'b0);
      repeat (4) @(posedge hclk);
      check(32'(ctrl.role_master), 32'(i[0] ^ i[1]));
      xfer(1'b0, 32'h24, 32'h0);
      check(d & 32'h2, 32'(i[1]) << 1);
    end
    xfer(1'b0, 32'h00, 32'h0);
    check(d, 32'h0);
    src_board_model_inst.set_pins(1'b0, 1'b0, 1'b0);
    src_board_model_inst.pulse_reset(500);
    check(32'(ctrl), 32'h0);
    run_wait();
    xfer(1'b0, 32'h2C, 32'h0);
    check(d & 32'h10, 32'h0);
    xfer(1'b0, 32'h24, 32'h0);
    check(d & 32'h6, 32'h0);
    xfer(1'b0, 32'h4C, 32'h0);
    check(d, 32'h0);
    tally_and_finish();
  end
endmodule
